// ---- src/miv_arbiter.sv ----
/*
 * Priority arbiter: picks the eligible source with the smallest
 * default priority number. Purely combinational.
 * Assumes priorities are unique per source.
 */
`timescale 1ns/100ps
module miv_arbiter #(
    parameter int NSRC = 17
) (
    input wire logic [NSRC-1:0] eligible,
    output miv_pkg::miv_idx_t win_idx,
    output logic win_valid
);
    import miv_pkg::*;
    `include "miv_consts.svh"

    localparam miv_prio_t PRIO [NSRC] = `MIV_PRIO_TABLE;

    // linear scan, keep strictly smaller number; ties cannot occur
    always_comb begin
        miv_prio_t best;
        best = 5'h1F;
        win_idx = 5'h00;
        win_valid = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (eligible[i] && (!win_valid || PRIO[i] < best)) begin
                best = PRIO[i];
                win_idx = miv_idx_t'(i);
                win_valid = 1'b1;
            end
        end
    end
endmodule // miv_arbiter

// ---- src/miv_consts.svh ----
/*
 * Constants of the maskable interrupt vectoring block: source count,
 * default priorities, vector addresses and enabling bit positions.
 * Assumes it is included by bare name from design files under src/.
 */
`ifndef MIV_CONSTS_SVH
`define MIV_CONSTS_SVH

`define MIV_NSRC 17
`define MIV_OPT_BYTE_ADDR 16'h00C0
`define MIV_WDT_EN_BIT 7
`define MIV_LVI_MODE_BIT 1

// default priorities, source index order
`define MIV_PRIO_TABLE '{5'h00, 5'h01, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, \
    5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E}
// vector table addresses, same order
`define MIV_VEC_TABLE '{16'h0004, 16'h0006, 16'h0030, 16'h0032, 16'h0036, 16'h0038, 16'h003C, \
    16'h0040, 16'h0042, 16'h0044, 16'h0046, 16'h0048, 16'h0052, 16'h0056, 16'h0058, 16'h005A, 16'h005E}

`endif

// ---- src/miv_ctrl.sv ----
/*
 * Maskable interrupt vectoring: latches source events as pending flags,
 * applies masks and enabling conditions, presents the winner with its
 * vector to the core and clears it on acknowledge.
 * Assumes event inputs are one-cycle pulses synchronous to clk and that
 * the core acknowledges only while irq_req is high.
 */
`timescale 1ns/100ps
module miv_ctrl #(
    parameter int NSRC = 17
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic irq_wdt_interval,
    input wire logic irq_lowvolt,
    input wire logic irq_tau0_ch2,
    input wire logic irq_tau0_ch3,
    input wire logic irq_rtc_cycle_alarm,
    input wire logic irq_rtc_interval,
    input wire logic irq_serial2_tx,
    input wire logic irq_tau1_ch3,
    input wire logic irq_tau0_ch4,
    input wire logic irq_tau0_ch5,
    input wire logic irq_tau0_ch6,
    input wire logic irq_tau0_ch7,
    input wire logic irq_ext_pin_ten,
    input wire logic irq_tau1_ch0,
    input wire logic irq_tau1_ch1,
    input wire logic irq_tau1_ch2,
    input wire logic irq_divide_done,
    input wire logic [7:0] option_byte,
    input wire logic [7:0] lowvolt_detect_control,
    input wire logic [NSRC-1:0] irq_mask,
    input wire logic irq_ack,
    output logic irq_req,
    output miv_pkg::miv_vec_t irq_vector,
    output miv_pkg::miv_idx_t irq_source,
    output logic [NSRC-1:0] irq_pending
);
    import miv_pkg::*;
    `include "miv_consts.svh"

    localparam miv_vec_t VEC [NSRC] = `MIV_VEC_TABLE;

    // the vector and priority tables are fixed at the documented source count
    if (NSRC != `MIV_NSRC) begin : g_bad_nsrc
        $error("miv_ctrl: NSRC must equal the source table size");
    end

    logic wdt_interval_irq_enable;
    logic lowvolt_detect_mode;
    logic [NSRC-1:0] raw_evt;
    logic [NSRC-1:0] pend_q, pend_d;
    logic [NSRC-1:0] eligible;
    logic [NSRC-1:0] ack_vec;
    miv_idx_t win_idx;
    logic win_valid;
    miv_state_t state_q, state_d;
    miv_idx_t src_q, src_d;
    miv_vec_t vec_q, vec_d;

    // enabling conditions for the two special sources
    assign wdt_interval_irq_enable = option_byte[`MIV_WDT_EN_BIT];
    assign lowvolt_detect_mode = lowvolt_detect_control[`MIV_LVI_MODE_BIT];

    // gather sources in table order
    assign raw_evt = {irq_divide_done, irq_tau1_ch2, irq_tau1_ch1, irq_tau1_ch0,
                      irq_ext_pin_ten, irq_tau0_ch7, irq_tau0_ch6, irq_tau0_ch5,
                      irq_tau0_ch4, irq_tau1_ch3, irq_serial2_tx, irq_rtc_interval,
                      irq_rtc_cycle_alarm, irq_tau0_ch3, irq_tau0_ch2,
                      irq_lowvolt & ~lowvolt_detect_mode,
                      irq_wdt_interval & wdt_interval_irq_enable};

    // masked flags stay pending but cannot compete
    assign eligible = pend_q & ~irq_mask;

    miv_arbiter #(.NSRC(NSRC)) u_arb (
        .eligible(eligible),
        .win_idx(win_idx),
        .win_valid(win_valid)
    );

    // one-hot of the source being acknowledged
    generate
        for (genvar g = 0; g < NSRC; g++) begin : g_ack
            // an acknowledge while the request is withdrawn by its mask is ignored
            assign ack_vec[g] = irq_ack && irq_req && (src_q == miv_idx_t'(g));
        end
    endgenerate

    // pending flags: a new event wins over the acknowledge clear
    always_comb begin
        pend_d = (pend_q & ~ack_vec) | raw_evt;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // presentation: the winner is frozen while presented so the vector is stable
    // until acknowledged; a newly arriving higher request waits one round
    always_comb begin
        state_d = state_q;
        src_d = src_q;
        vec_d = vec_q;
        case (state_q)
            MIV_IDLE: begin
                if (win_valid) begin
                    state_d = MIV_PRESENT;
                    src_d = win_idx;
                    vec_d = VEC[win_idx];
                end
            end
            MIV_PRESENT: begin
                if (irq_ack || irq_mask[src_q]) begin
                    state_d = MIV_IDLE; // withdraw when masked
                end
            end
            default: state_d = MIV_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= MIV_IDLE;
            src_q <= 5'h00;
            vec_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            vec_q <= vec_d;
        end
    end

    assign irq_req = (state_q == MIV_PRESENT) && !irq_mask[src_q];
    assign irq_vector = vec_q;
    assign irq_source = src_q;
    assign irq_pending = pend_q;

    // checks
    wdt_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        (!pend_q[MIV_WDTI] && !option_byte[`MIV_WDT_EN_BIT]) |=> !pend_q[MIV_WDTI])
        else $error("watchdog interval pended while disabled");
    lvi_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        (!pend_q[MIV_LVI] && lowvolt_detect_control[`MIV_LVI_MODE_BIT]) |=> !pend_q[MIV_LVI])
        else $error("low-voltage pended in reset mode");
    masked_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        irq_req |-> !irq_mask[src_q])
        else $error("masked source presented");
    ack_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && irq_ack && !raw_evt[src_q]) |=> !pend_q[$past(src_q)])
        else $error("acknowledged flag not cleared");
    keep_pend_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && irq_ack && $countones(pend_q) > 1) |=> $countones(pend_q) >= 1)
        else $error("other pending flags lost");
    tau02_vec_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && src_q == 5'h02) |-> irq_vector == 16'h0030)
        else $error("wrong vector for timer 0 ch2");
    div_vec_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && src_q == 5'h10) |-> irq_vector == 16'h005E)
        else $error("wrong vector for divider");
    ext_vec_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_req && src_q == 5'h0C) |-> irq_vector == 16'h0052)
        else $error("wrong vector for pin ten");
    prio_pick_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == MIV_IDLE && eligible[0]) |=> (state_q == MIV_PRESENT && src_q == 5'h00))
        else $error("highest priority not chosen");
    rtc_pick_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == MIV_IDLE && eligible[4] && eligible[5] && eligible[3:0] == 4'h0)
        |=> src_q == 5'h04)
        else $error("rtc ordering wrong");
    skip_mask_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == MIV_IDLE && pend_q[2] && irq_mask[2] && eligible[16] && eligible[15:0] == '0)
        |=> src_q == 5'h10)
        else $error("masked source blocked arbitration");

    ack_seen_c: cover property (@(posedge clk) disable iff (!resetn) irq_req && irq_ack);
    two_pend_c: cover property (@(posedge clk) disable iff (!resetn) $countones(eligible) > 1);
    masked_c: cover property (@(posedge clk) disable iff (!resetn) (pend_q & irq_mask) != '0);
endmodule // miv_ctrl

// ---- src/miv_pkg.sv ----
/*
 * Types of the maskable interrupt vectoring block.
 * Assumes miv_consts.svh is on the include path.
 */
package miv_pkg;
`include "miv_consts.svh"
    typedef logic [4:0] miv_prio_t;
    typedef logic [15:0] miv_vec_t;
    typedef logic [4:0] miv_idx_t;
    // source order; index equals table position
    typedef enum {
        MIV_WDTI, MIV_LVI, MIV_TAU0_CH2, MIV_TAU0_CH3, MIV_RTC, MIV_RTCI, MIV_ST2, MIV_TAU1_CH3,
        MIV_TAU0_CH4, MIV_TAU0_CH5, MIV_TAU0_CH6, MIV_TAU0_CH7, MIV_EXT10, MIV_TAU1_CH0,
        MIV_TAU1_CH1, MIV_TAU1_CH2, MIV_DIV
    } miv_src_t;
    typedef enum {MIV_IDLE, MIV_PRESENT} miv_state_t;
endpackage

// ---- testbench/miv_core_model.sv ----
/*
 * Behavioural model of the processor core side: acknowledges each presented request.
 * Assumes irq_req is settled before each rising edge of clk.
 */
`timescale 1ns/100ps
module miv_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic irq_req,
    input wire logic [1:0] ack_delay,
    output logic irq_ack
);
    logic [1:0] wait_q;

    // one-cycle acknowledge after ack_delay cycles; slow cores show that the winner stays frozen
    always @(posedge clk) begin
        if (!resetn || !irq_req || irq_ack) begin
            wait_q <= 2'h0;
            irq_ack <= 1'b0;
        end else if (wait_q == ack_delay) begin
            irq_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule // miv_core_model

// ---- testbench/miv_ctrl_test.sv ----
/*
 * Self-checking bench of the interrupt vectoring block with a reference model.
 * Assumes the core model acknowledges only while irq_req is high.
 */
`timescale 1ns/100ps
module miv_ctrl_test;
    import miv_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic irq_ack;
    logic irq_req;
    logic [1:0] ack_delay = 2'h0;
    logic [7:0] opt_byte = 8'h00;
    logic [7:0] lv_ctrl = 8'h00;
    logic [16:0] ev = 17'h00000;
    logic [16:0] mask = 17'h00000;
    logic [16:0] irq_pending;
    logic [16:0] p = 17'h00000;
    miv_vec_t irq_vector;
    miv_idx_t irq_source;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int w;
    int cur = -1;
    logic [31:0] rnd = 32'hEA580210;
    logic [15:0] vec_tab [17] = '{16'h0004, 16'h0006, 16'h0030, 16'h0032, 16'h0036, 16'h0038, 16'h003C,
        16'h0040, 16'h0042, 16'h0044, 16'h0046, 16'h0048, 16'h0052, 16'h0056, 16'h0058, 16'h005A, 16'h005E};

    // 125 MHz clock
    always #4 clk = ~clk;

    miv_ctrl dut (.clk(clk), .resetn(resetn), .irq_wdt_interval(ev[0]), .irq_lowvolt(ev[1]),
        .irq_tau0_ch2(ev[2]), .irq_tau0_ch3(ev[3]), .irq_rtc_cycle_alarm(ev[4]), .irq_rtc_interval(ev[5]),
        .irq_serial2_tx(ev[6]), .irq_tau1_ch3(ev[7]), .irq_tau0_ch4(ev[8]), .irq_tau0_ch5(ev[9]),
        .irq_tau0_ch6(ev[10]), .irq_tau0_ch7(ev[11]), .irq_ext_pin_ten(ev[12]), .irq_tau1_ch0(ev[13]),
        .irq_tau1_ch1(ev[14]), .irq_tau1_ch2(ev[15]), .irq_divide_done(ev[16]), .option_byte(opt_byte),
        .lowvolt_detect_control(lv_ctrl), .irq_mask(mask), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_source(irq_source), .irq_pending(irq_pending));
    miv_core_model core (.clk(clk), .resetn(resetn), .irq_req(irq_req), .ack_delay(ack_delay),
        .irq_ack(irq_ack));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // priorities run 0, 1, then 16 upward in source order
    function automatic int prio(input int i);
        return (i < 2) ? i : i + 14;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic results;
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // reference model: the winner is chosen when idle and held until acknowledged or masked;
    // the acknowledge clear comes before new events, so a set in the same cycle wins
    always @(posedge clk) begin
        int win;
        cyc++;
        if (cyc > 20000) begin
            fails++;
            results();
        end
        if (!resetn) begin
            cur = -1;
        end else if (cur >= 0) begin
            chk("request", 32'(!mask[cur]), 32'(irq_req));
            if (irq_ack && !mask[cur]) begin
                chk("source", 32'(cur), 32'(irq_source));
                chk("vector", 32'(vec_tab[cur]), 32'(irq_vector));
                p[cur] = 1'b0;
                cur = -1;
            end else if (mask[cur]) begin
                cur = -1;
            end
        end else begin
            chk("request", 32'h0, 32'(irq_req));
            win = -1;
            for (int i = 0; i < 17; i++) if (p[i] && !mask[i] && (win < 0 || prio(i) < prio(win))) win = i;
            cur = win;
        end
        for (int i = 0; i < 17; i++) begin
            if (resetn && ev[i] && (i != 0 || opt_byte[7]) && (i != 1 || !lv_ctrl[1])) p[i] = 1'b1;
        end
    end

    // rounds of simultaneous events under random masks and enabling bits, then drain
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("pending after reset", 32'h0, 32'(irq_pending));
        for (int r = 0; r < 40; r++) begin
            rnd = lfsr(rnd);
            ev <= (r == 0) ? 17'h1FFFF : rnd[16:0];
            opt_byte <= (r == 0) ? 8'h80 : {rnd[20], 7'h00};
            lv_ctrl <= (r == 0) ? 8'h00 : {6'h00, rnd[21], 1'b0};
            ack_delay <= rnd[23:22];
            rnd = lfsr(rnd);
            mask <= (r == 0) ? 17'h00000 : rnd[16:0] & rnd[31:15];
            @(posedge clk);
            ev <= 17'h00000;
            w = 0;
            while (w < 6) begin
                @(posedge clk);
                w = irq_req ? 0 : w + 1;
            end
            chk("pending", 32'(p), 32'(irq_pending));
        end
        results();
    end
endmodule // miv_ctrl_test
